// >>> verilog/adc_fmt_pkg.sv
// How it works
// - left justify: result 9:2 fills high byte
// - left justify: result 1:0 in low 7:6
// - left justify: low byte 5:0 reserved
// - right justify: result 9:8 in high 1:0
// - right justify: high byte 7:2 reserved
// - right justify: result 7:0 fills low byte
// - hold capacitor never discharged between conversions
// - justify select 1 right, 0 left
// - go starts conversion, hardware clears when done
package adc_fmt_pkg;

   // =====================================================
   // register byte offsets on the apb bus
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] ASEL_OFF = 8'h04;
   localparam logic [7:0] RESH_OFF = 8'h08;
   localparam logic [7:0] RESL_OFF = 8'h0c;
   localparam logic [7:0] ICORE_OFF = 8'h10;
   localparam logic [7:0] IEN_OFF = 8'h14;
   localparam logic [7:0] IFLAG_OFF = 8'h18;

   // =====================================================
   // field positions
   localparam int JUSTIFY_BIT = 7;
   localparam int VREF_BIT = 6;
   localparam int CHAN_LSB = 2;
   localparam int GO_BIT = 1;
   localparam int ON_BIT = 0;
   localparam int DIV_LSB = 4;
   localparam int DONE_BIT = 6;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_EN_BIT = 6;

   // =====================================================
   // reset values and writable masks
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hcf;
   localparam logic [7:0] ASEL_RST = 8'h0f;
   localparam logic [7:0] ASEL_WMASK = 8'h7f;
   localparam logic [7:0] ICORE_RST = 8'h00;
   localparam logic [7:0] IEN_RST = 8'h00;
   localparam logic [7:0] IEN_WMASK = 8'hef;
   localparam logic [7:0] IFLAG_RST = 8'h00;
   localparam logic [7:0] RES_RST = 8'h00;

   // =====================================================
   // conversion timing: ticks of the conversion clock per result
   localparam int CONV_TICKS = 11;
   localparam int SAMPLE_W = 10;
   localparam int CHANNELS = 4;

   // acquisition figures that software must respect
   localparam int AMP_SETTLE_NS = 2000;
   // temperature term is 50 ns per degree above the reference
   localparam int TEMP_COEFF_NS_PER_C = 50;
   localparam int TEMP_REF_C = 25;

   // control register layout
   typedef struct packed {
      logic justify;
      logic vref;
      logic [1:0] unused;
      logic [1:0] chan;
      logic go;
      logic on;
   } ctrl_type;

   // formatted result pair
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } result_pair_type;

endpackage

// >>> verilog/conv_engine.sv
// =====================================================
// conversion sequencer: divider, tick counter, hold stage
module conv_engine #(
   parameter int WIDTH = 10,
   parameter int TICKS = 11
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic [2:0] div_sel_in,
   input wire logic [WIDTH-1:0] sample_in,
   output logic busy_out,
   output logic done_out,
   output logic [WIDTH-1:0] result_out
);

   // elaboration check: the tick counter is only eight bits wide
   if (WIDTH < 1 || TICKS < 1 || TICKS > 255)
   begin : g_bad_params
      $error("conv_engine: unsupported parameters");
   end

   logic [7:0] div_r, div_nxt;
   logic [7:0] tick_cnt_r, tick_cnt_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic [WIDTH-1:0] hold_r, hold_nxt;
   logic [WIDTH-1:0] result_r, result_nxt;
   logic [7:0] div_top;
   logic tick;

   // =====================================================
   // next state
   always_comb
   begin
      // divide by 2 << sel gives one-cycle tick enables
      div_top = 8'((16'h0002 << div_sel_in) - 16'h0001);
      tick = busy_r && (div_r == div_top);
      div_nxt = div_r;
      tick_cnt_nxt = tick_cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      hold_nxt = hold_r;
      result_nxt = result_r;
      if (abort_in)
      begin
         busy_nxt = 1'b0;
      end
      else if (start_in && !busy_r)
      begin
         // hold keeps charge
         // hold stage is only overwritten, never cleared between runs
         hold_nxt = sample_in;
         busy_nxt = 1'b1;
         div_nxt = 8'h00;
         tick_cnt_nxt = 8'h00;
      end
      else if (busy_r)
      begin
         div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
         if (tick)
         begin
            if (tick_cnt_r == 8'(TICKS - 1))
            begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               result_nxt = hold_r;
            end
            else
            begin
               tick_cnt_nxt = 8'(tick_cnt_r + 8'h01);
            end
         end
      end
   end

   // =====================================================
   // registers; hold and result have no reset, like the capacitor
   always_ff @(posedge clock_in)
   begin
      hold_r <= hold_nxt;
      result_r <= result_nxt;
      if (rst_in)
      begin
         div_r <= 8'h00;
         tick_cnt_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy_out = busy_r;
   assign done_out = done_r;
   assign result_out = result_r;

endmodule

// >>> verilog/adc_result_format_regs.sv
// =====================================================
// converter control and result formatting behind an apb slave
//
// Implementation choices: the APB slave port and the address map.
module adc_result_format_regs #(
   parameter int CHANNELS = adc_fmt_pkg::CHANNELS,
   parameter int SAMPLE_W = adc_fmt_pkg::SAMPLE_W
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [CHANNELS*SAMPLE_W-1:0] analog_sample_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic conv_busy_out,
   output logic vref_sel_out,
   output logic [3:0] analog_enable_out
);

   // =====================================================
   // parameter checks: formatting is fixed at ten bits, four channels
   if (SAMPLE_W != 10 || CHANNELS != 4)
   begin : g_bad_params
      $error("adc_result_format_regs: only 10-bit, 4-channel supported");
   end

   // =====================================================
   // declarations
   adc_fmt_pkg::ctrl_type ctrl_r, ctrl_nxt;
   logic [7:0] asel_r, asel_nxt;
   logic [7:0] resh_r, resh_nxt;
   logic [7:0] resl_r, resl_nxt;
   logic [7:0] icore_r, icore_nxt;
   logic [7:0] ien_r, ien_nxt;
   logic [7:0] iflag_r, iflag_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic irq_r, irq_nxt;
   logic [CHANNELS*SAMPLE_W-1:0] sync1_r, sync2_r;
   logic [SAMPLE_W-1:0] chan_sample;
   logic eng_start, eng_abort, eng_busy, eng_done;
   logic [SAMPLE_W-1:0] eng_result;
   adc_fmt_pkg::result_pair_type fmt;
   logic access_done, wr_done, rd_done, addr_hit;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;

   // =====================================================
   // analog side is another domain: two flops per channel first
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin : g_sync
         always_ff @(posedge clock_in)
         begin
            sync1_r[ch*SAMPLE_W +: SAMPLE_W] <= analog_sample_in[ch*SAMPLE_W +: SAMPLE_W];
            sync2_r[ch*SAMPLE_W +: SAMPLE_W] <= sync1_r[ch*SAMPLE_W +: SAMPLE_W];
         end
      end
   endgenerate

   // channel mux reads only the second flop stage
   always_comb
   begin
      chan_sample = sync2_r[ctrl_r.chan*SAMPLE_W +: SAMPLE_W];
   end

   // =====================================================
   // conversion sequencer
   conv_engine #(
      .WIDTH(SAMPLE_W),
      .TICKS(adc_fmt_pkg::CONV_TICKS)
   ) u_engine (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .start_in(eng_start),
      .abort_in(eng_abort),
      .div_sel_in(asel_r[adc_fmt_pkg::DIV_LSB +: 3]),
      .sample_in(chan_sample),
      .busy_out(eng_busy),
      .done_out(eng_done),
      .result_out(eng_result)
   );

   // =====================================================
   // result formatting
   always_comb
   begin
      fmt.high = 8'h00;
      fmt.low = 8'h00;
      if (ctrl_r.justify)
      begin
         fmt.high[1:0] = eng_result[9:8];
         fmt.high[7:2] = 6'h00;
         fmt.low = eng_result[7:0];
      end
      else
      begin
         fmt.high = eng_result[9:2];
         fmt.low[7:6] = eng_result[1:0];
         fmt.low[5:0] = 6'h00;
      end
   end

   // =====================================================
   // apb decode and read mux
   always_comb
   begin
      access_done = psel_in && penable_in && pready_r;
      wr_done = access_done && pwrite_in;
      rd_done = access_done && !pwrite_in;
      wbyte = pwdata_in[7:0];
      addr_hit = 1'b1;
      unique case (paddr_in)
         adc_fmt_pkg::CTRL_OFF: rd_byte = ctrl_r;
         adc_fmt_pkg::ASEL_OFF: rd_byte = asel_r;
         adc_fmt_pkg::RESH_OFF: rd_byte = resh_r;
         adc_fmt_pkg::RESL_OFF: rd_byte = resl_r;
         adc_fmt_pkg::ICORE_OFF: rd_byte = icore_r;
         adc_fmt_pkg::IEN_OFF: rd_byte = ien_r;
         adc_fmt_pkg::IFLAG_OFF: rd_byte = iflag_r;
         default:
         begin
            rd_byte = 8'h00;
            addr_hit = 1'b0;
         end
      endcase
   end

   // =====================================================
   // bus handshake: one wait state, data and error registered
   always_comb
   begin
      pready_nxt = psel_in && penable_in && !pready_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (psel_in && penable_in && !pready_r)
      begin
         prdata_nxt = pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_nxt = !addr_hit;
      end
   end

   // =====================================================
   // control, select and result registers
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      asel_nxt = asel_r;
      resh_nxt = resh_r;
      resl_nxt = resl_r;
      icore_nxt = icore_r;
      ien_nxt = ien_r;
      eng_start = 1'b0;
      eng_abort = 1'b0;
      if (wr_done)
      begin
         unique case (paddr_in)
            adc_fmt_pkg::CTRL_OFF:
            begin
               ctrl_nxt = wbyte & adc_fmt_pkg::CTRL_WMASK;
               // go write starts
               // a start needs the converter on; else go stays low
               ctrl_nxt.go = wbyte[adc_fmt_pkg::GO_BIT] && wbyte[adc_fmt_pkg::ON_BIT];
               eng_start = ctrl_nxt.go && !eng_busy;
               // clearing go or turning off aborts a running conversion
               eng_abort = !ctrl_nxt.go && eng_busy;
               if (ctrl_r.go && ctrl_nxt.go)
                  eng_start = 1'b0;
            end
            adc_fmt_pkg::ASEL_OFF: asel_nxt = wbyte & adc_fmt_pkg::ASEL_WMASK;
            adc_fmt_pkg::RESH_OFF: resh_nxt = wbyte;
            adc_fmt_pkg::RESL_OFF: resl_nxt = wbyte;
            adc_fmt_pkg::ICORE_OFF: icore_nxt = wbyte;
            adc_fmt_pkg::IEN_OFF: ien_nxt = wbyte & adc_fmt_pkg::IEN_WMASK;
            default: ctrl_nxt = ctrl_r;
         endcase
      end
      if (eng_done)
      begin
         ctrl_nxt.go = 1'b0;
         // results load with clear
         // completion beats a same-cycle software write to the results
         resh_nxt = fmt.high;
         resl_nxt = fmt.low;
      end
   end

   // =====================================================
   // interrupt flags: set by completion, cleared by reading them
   always_comb
   begin
      iflag_nxt = iflag_r;
      // clear only what the read returned, so a later event survives
      if (rd_done && paddr_in == adc_fmt_pkg::IFLAG_OFF)
         iflag_nxt = iflag_r & ~prdata_r[7:0];
      // set wins over the read clear
      if (eng_done)
         iflag_nxt[adc_fmt_pkg::DONE_BIT] = 1'b1;
      irq_nxt = icore_r[adc_fmt_pkg::GLOBAL_EN_BIT] && icore_r[adc_fmt_pkg::PERIPH_EN_BIT]
         && |(iflag_nxt & ien_r);
   end

   // =====================================================
   // state registers
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ctrl_r <= adc_fmt_pkg::CTRL_RST;
         asel_r <= adc_fmt_pkg::ASEL_RST;
         icore_r <= adc_fmt_pkg::ICORE_RST;
         ien_r <= adc_fmt_pkg::IEN_RST;
         iflag_r <= adc_fmt_pkg::IFLAG_RST;
         resh_r <= adc_fmt_pkg::RES_RST;
         resl_r <= adc_fmt_pkg::RES_RST;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         asel_r <= asel_nxt;
         icore_r <= icore_nxt;
         ien_r <= ien_nxt;
         iflag_r <= iflag_nxt;
         resh_r <= resh_nxt;
         resl_r <= resl_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
      end
   end

   // =====================================================
   // outputs, all straight from flops
   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign irq_out = irq_r;
   assign conv_busy_out = ctrl_r.go;
   assign vref_sel_out = ctrl_r.vref;
   assign analog_enable_out = asel_r[3:0];

endmodule

// >>> sim/adc_fmt_monitor.sv
// ==========
// port checker for the result format block
module adc_fmt_monitor (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic conv_busy_out,
   input wire logic vref_sel_out,
   input wire logic [3:0] analog_enable_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   logic wr_done;
   logic ctrl_wr;
   // a write taken at this edge
   assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
   assign ctrl_wr = wr_done && paddr_in == adc_fmt_pkg::CTRL_OFF;
   chk_ready_wait: assert property (psel_in && penable_in && !$past(penable_in)
      |-> !pready_out ##1 pready_out) else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   chk_ready_access: assert property (pready_out |-> psel_in && penable_in)
      else $error("ready outside access phase");
   chk_err_unmapped: assert property (pready_out && paddr_in > 8'h18 |-> pslverr_out)
      else $error("unmapped address not refused");
   chk_err_mapped: assert property (pready_out && paddr_in <= 8'h18 && paddr_in[1:0] == 2'h0
      |-> !pslverr_out) else $error("mapped address refused");
   chk_read_upper: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_go_start: assert property (ctrl_wr && pwdata_in[1:0] == 2'h3 && !conv_busy_out
      |=> conv_busy_out) else $error("go did not start");
   chk_go_refused: assert property (ctrl_wr && !pwdata_in[0] |=> !conv_busy_out)
      else $error("go kept while off");
   chk_vref_follow: assert property (ctrl_wr |=> vref_sel_out == $past(pwdata_in[6]))
      else $error("vref select wrong");
   chk_enable_follow: assert property (wr_done && paddr_in == adc_fmt_pkg::ASEL_OFF
      |=> analog_enable_out == $past(pwdata_in[3:0])) else $error("enable wrong");
   cover property ($fell(conv_busy_out));
   cover property (pslverr_out);
   cover property (ctrl_wr && !pwdata_in[0]);
endmodule

bind adc_result_format_regs adc_fmt_monitor adc_fmt_monitor_i (
   .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
   .prdata_out, .pready_out, .pslverr_out, .conv_busy_out, .vref_sel_out,
   .analog_enable_out
);

// >>> sim/test_adc_result_format_regs.sv
// ==========
// register level bench over apb
module test_adc_result_format_regs;
   timeunit 1ns;
   timeprecision 1ps;
   // charge time and die temperature are board assumptions
   localparam int HOLD_NS = 1370;
   localparam int TEMP_C = 50;
   localparam int ACQ = (adc_fmt_pkg::AMP_SETTLE_NS + HOLD_NS
      + (TEMP_C - adc_fmt_pkg::TEMP_REF_C) * adc_fmt_pkg::TEMP_COEFF_NS_PER_C) / 10 + 1;
   localparam logic [7:0] CT = adc_fmt_pkg::CTRL_OFF;
   localparam logic [7:0] FL = adc_fmt_pkg::IFLAG_OFF;
   localparam logic [7:0] EN = adc_fmt_pkg::IEN_OFF;
   logic clock_in;
   logic rst_in;
   logic psel_in;
   logic penable_in;
   logic pwrite_in;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in;
   logic [39:0] analog_sample_in;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic irq_out;
   logic conv_busy_out;
   logic vref_sel_out;
   logic [3:0] analog_enable_out;
   int failures;
   int compares;
   logic [7:0] c;
   adc_fmt_pkg::result_pair_type ex;

   adc_result_format_regs adc_result_format_regs_i (
      .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .analog_sample_in, .prdata_out, .pready_out, .pslverr_out, .irq_out,
      .conv_busy_out, .vref_sel_out, .analog_enable_out
   );

   // ==========
   // clock and watchdog
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial
   begin
      #200000;
      fail("watchdog");
      close_out;
   end

   task automatic fail(input string m);
      failures++;
      $display("mismatch %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      compares++;
      if (g !== x)
         fail(m);
   endtask
   // one apb transfer, held until ready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      // ready and data are taken as they stood at the rising edge
      do
      begin
         @(posedge clock_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 16);
      if (pready_out !== 1'b1)
         fail("no ready");
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic ee);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, {24'h0, x}, "read data");
      chk({31'h0, e}, {31'h0, ee}, "error flag");
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h0, d}, q, e);
   endtask
   task automatic irq_is(input logic x);
      @(posedge clock_in);
      chk({31'h0, irq_out}, {31'h0, x}, "irq level");
      @(posedge clock_in);
   endtask
   // channel first, then go after the acquisition wait
   task automatic conv(input logic [7:0] cv);
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      wr(CT, cv & 8'hfd);
      repeat (ACQ) @(posedge clock_in);
      wr(CT, cv);
      do
      begin
         apb(1'b0, CT, 32'h0, q, e);
         n++;
      end
      while (q[1] !== 1'b0 && n < 40);
      chk(q, {24'h0, cv & 8'hfd}, "go not cleared");
   endtask
   function automatic adc_fmt_pkg::result_pair_type fmt(input logic j, input logic [9:0] r);
      return j ? {6'h00, r} : {r, 6'h00};
   endfunction

   task automatic close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========
   // main sequence
   initial
   begin
      failures = 0;
      compares = 0;
      rst_in = 1'b1;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      analog_sample_in = {10'h3c5, 10'h2d5, 10'h0ff, 10'h301};
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rd(CT, adc_fmt_pkg::CTRL_RST, 1'b0);
      rd(adc_fmt_pkg::ASEL_OFF, adc_fmt_pkg::ASEL_RST, 1'b0);
      rd(adc_fmt_pkg::RESH_OFF, adc_fmt_pkg::RES_RST, 1'b0);
      rd(adc_fmt_pkg::RESL_OFF, adc_fmt_pkg::RES_RST, 1'b0);
      rd(adc_fmt_pkg::ICORE_OFF, adc_fmt_pkg::ICORE_RST, 1'b0);
      rd(EN, adc_fmt_pkg::IEN_RST, 1'b0);
      rd(FL, adc_fmt_pkg::IFLAG_RST, 1'b0);
      rd(8'h1c, 8'h00, 1'b1);
      wr(CT, 8'h02);
      rd(CT, 8'h00, 1'b0);
      $display("test reset and refusal done");
      // every channel, both justifications, slower divider last
      for (int i = 0; i < 4; i++)
      begin
         if (i == 3)
            wr(adc_fmt_pkg::ASEL_OFF, 8'h1a);
         c = {i[0], 3'b000, i[1:0], 2'b11};
         conv(c);
         ex = fmt(i[0], analog_sample_in[i*10+:10]);
         rd(adc_fmt_pkg::RESH_OFF, ex.high, 1'b0);
         rd(adc_fmt_pkg::RESL_OFF, ex.low, 1'b0);
         rd(FL, 8'h40, 1'b0);
         rd(FL, 8'h00, 1'b0);
         irq_is(1'b0);
      end
      rd(adc_fmt_pkg::ASEL_OFF, 8'h1a, 1'b0);
      $display("test conversions done");
      wr(EN, 8'h40);
      wr(adc_fmt_pkg::ICORE_OFF, 8'hc0);
      conv(8'h87);
      irq_is(1'b1);
      rd(FL, 8'h40, 1'b0);
      irq_is(1'b0);
      wr(EN, 8'h00);
      conv(8'h03);
      irq_is(1'b0);
      rd(FL, 8'h40, 1'b0);
      $display("test interrupt done");
      close_out;
   end
endmodule
